// file: design/reset_defs.svh
`ifndef RESET_DEFS_SVH
`define RESET_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_CAUSE 8'h00
`define OFS_WDCTRL 8'h04
`define OFS_STATUS 8'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_DEBUG_FLAG 4
`define BIT_WDT_FLAG 3
`define BIT_BROWNOUT_FLAG 2
`define BIT_PIN_FLAG 1
`define BIT_POWER_FLAG 0
`define BIT_TURNOFF 4
`define BIT_WD_ENABLE 3
`define PRESCALE_MSB 2
`define PRESCALE_LSB 0

// ****************************************************************
// Reset values
// ****************************************************************
`define CAUSE_RESET 5'h00
`define WDCTRL_RESET 5'h00

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_SYS_HZ 10000000
`define WDT_OSC_HZ 1000000
`define WDT_OSC_DIV (`CLK_SYS_HZ / `WDT_OSC_HZ)
`define BOD_MIN_NS 2000
`define BOD_MIN_CYC ((`BOD_MIN_NS * (`CLK_SYS_HZ / 1000000) + 999) / 1000)
`define TOE_HOLD_CYC 4
`define WDT_BASE_CYC 16384
`define START_BASE_CYC 16

`endif

// file: design/reset_pkg.sv
package reset_pkg;

    typedef struct packed {
        logic debug;
        logic wdt;
        logic brownout;
        logic pin;
        logic power_on;
    } cause_flags_t;

    typedef struct packed {
        logic turnoff;
        logic enable;
        logic [2:0] prescale;
    } wd_ctrl_t;

    typedef enum logic [1:0] {
        SEQ_HOLD = 2'b00,
        SEQ_STRETCH = 2'b01,
        SEQ_RUN = 2'b10
    } seq_state_t;

endpackage

// file: design/reset_source_and_watchdog.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "reset_defs.svh"

// Function
// - Hold reset while power-on detector is low, then stretch by startup delay.
// - Power-on detector falling again reasserts reset at once, no counting.
// - Low reset pin forces internal reset asynchronously, even without clock.
// - After the reset pin rises, run the startup delay before release.
// - Brownout level select picks 2.7V unprogrammed, 4.0V programmed.
// - Enabled brownout asserts reset at once; release after startup delay.
// - Brownout counts only if low supply lasts longer than minimum period.
// - Watchdog timeout gives a one-cycle pulse; delay starts after it.
// - Debug reset flag bit 4 set by debug request; cleared by POR/zero.
// - Watchdog flag bit 3 set on watchdog reset; cleared by POR/zero.
// - Brownout flag bit 2 set on brownout reset; cleared by POR/zero.
// - Pin flag bit 1 set on pin reset; cleared by POR/zero write.
// - Power-on flag bit 0 set on POR; only a zero write clears it.
// - Bandgap on when brownout enabled, comparator select, or converter on.
// - Watchdog counts 1 MHz oscillator ticks; restart clears the counter.
// - Watchdog counter also cleared when disabled and during chip reset.
// - Timeout without restart while enabled causes a watchdog reset.
// - Turn-off enable bit clears itself four clocks after written one.
// - Enable write one sets; zero only clears while turn-off bit is one.
// - Prescale code sets timeout, 16384 doubling to 2097152 oscillator cycles.
// - Watchdog control bits 7 to 5 read as zero.
// - Startup delay length chosen by an external clock-source setting.
module reset_source_and_watchdog
    import reset_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int WDT_W = 22,
    parameter int WDT_BASE = `WDT_BASE_CYC,
    parameter int START_W = 16,
    parameter int START_BASE = `START_BASE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rst_pin_n,
    input wire logic por_low,
    input wire logic brownout_detector,
    input wire logic brownout_enable_setting,
    input wire logic brownout_level_select,
    input wire logic debug_reset_req,
    input wire logic watchdog_restart,
    input wire logic comparator_bandgap_select,
    input wire logic converter_enable,
    input wire logic [1:0] startup_delay_select,
    output logic chip_reset,
    output logic wdt_reset_pulse,
    output logic bandgap_enable,
    output logic brownout_level_high
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    localparam int OSC_DIV = `WDT_OSC_DIV;
    localparam int BOD_MIN = `BOD_MIN_CYC;

    generate
        if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
            $error("address width out of range");
        end
        if ((longint'(WDT_BASE) << 7) >= (longint'(1) << WDT_W)) begin : g_bad_wdt
            $error("watchdog counter too narrow for longest timeout");
        end
        if ((longint'(START_BASE) << 6) >= (longint'(1) << START_W)) begin : g_bad_st
            $error("startup counter too narrow for longest delay");
        end
        if (WDT_BASE < 1 || START_BASE < 1 || OSC_DIV < 1 || OSC_DIV > 255) begin : g_bad
            $error("timing parameters out of range");
        end
    endgenerate

    // ****************************************************************
    // Declarations
    // ****************************************************************
    cause_flags_t cause;
    cause_flags_t next_cause;
    wd_ctrl_t wd_ctrl;
    wd_ctrl_t next_wd_ctrl;
    seq_state_t state;
    seq_state_t next_state;
    logic pin_pending;
    logic [START_W-1:0] delay_cnt;
    logic [START_W-1:0] next_delay_cnt;
    logic [START_W-1:0] delay_len;
    logic [7:0] bod_cnt;
    logic bod_valid;
    logic [7:0] osc_div;
    logic osc_tick;
    logic [WDT_W-1:0] wdt_cnt;
    logic [WDT_W-1:0] wdt_limit;
    logic wdt_expire;
    logic [2:0] toe_cnt;
    logic any_src;
    logic next_chip_reset;
    logic access;
    logic wr_fire;
    logic sel_cause;
    logic sel_wdctrl;
    logic sel_status;
    logic addr_hit;
    logic [31:0] rd_mux;
    logic [4:0] wr_bits;
    logic toe_write;
    logic en_write_zero;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign access = psel && penable && !pready;
    assign wr_fire = psel && penable && pready && pwrite;
    assign sel_cause = (paddr == ADDR_W'(`OFS_CAUSE));
    assign sel_wdctrl = (paddr == ADDR_W'(`OFS_WDCTRL));
    assign sel_status = (paddr == ADDR_W'(`OFS_STATUS));
    assign addr_hit = sel_cause || sel_wdctrl || sel_status;
    assign wr_bits = pwdata[4:0];

    // Upper bits of the watchdog control word are not stored at all
    assign rd_mux = sel_cause ? {27'h0000000, cause} :
                    sel_wdctrl ? {27'h0000000, wd_ctrl} :
                    sel_status ? {29'h0000000, state, chip_reset} :
                    32'h00000000;

    // One wait state keeps prdata and pready registered
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= access && !addr_hit;
            prdata <= access ? (pwrite ? 32'h00000000 : rd_mux) : prdata;
        end
    end

    // ****************************************************************
    // Reset sources
    // ****************************************************************
    // Pin low is caught asynchronously so a stopped clock still resets
    always_ff @(posedge clk_sys or negedge rst_pin_n) begin
        if (!rst_pin_n) begin
            pin_pending <= 1'b1;
        end else begin
            pin_pending <= 1'b0;
        end
    end

    // Short supply dips never reach the sequencer
    always_ff @(posedge clk_sys) begin
        if (rst || !brownout_detector || !brownout_enable_setting) begin
            bod_cnt <= 8'h00;
        end else if (bod_cnt != 8'(BOD_MIN)) begin
            bod_cnt <= bod_cnt + 8'h01;
        end
    end

    assign bod_valid = brownout_enable_setting && brownout_detector &&
                       (bod_cnt == 8'(BOD_MIN));

    assign any_src = por_low || pin_pending || bod_valid ||
                     debug_reset_req || wdt_reset_pulse;

    // ****************************************************************
    // Reset sequencer
    // ****************************************************************
    assign delay_len = START_W'(START_BASE) << {startup_delay_select, 1'b0};

    // Any active source reloads the delay, so a new dip restarts it
    assign next_delay_cnt = any_src ? delay_len :
                            (delay_cnt != '0) ? delay_cnt - 1'b1 :
                            delay_cnt;
    assign next_chip_reset = any_src || (delay_cnt != '0);
    assign next_state = any_src ? SEQ_HOLD :
                        (delay_cnt != '0) ? SEQ_STRETCH : SEQ_RUN;

    always_ff @(posedge clk_sys or negedge rst_pin_n) begin
        if (!rst_pin_n) begin
            chip_reset <= 1'b1;
        end else if (rst) begin
            chip_reset <= 1'b1;
        end else begin
            chip_reset <= next_chip_reset;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            delay_cnt <= '0;
            state <= SEQ_HOLD;
        end else begin
            delay_cnt <= next_delay_cnt;
            unique case (next_state)
                SEQ_HOLD: state <= SEQ_HOLD;
                SEQ_STRETCH: state <= SEQ_STRETCH;
                SEQ_RUN: state <= SEQ_RUN;
            endcase
        end
    end

    // ****************************************************************
    // Reset cause flags
    // ****************************************************************
    // Hardware set wins over a software clear in the same cycle
    always_comb begin
        next_cause = cause;
        if (wr_fire && sel_cause) begin
            next_cause = cause & wr_bits;
        end
        if (por_low) begin
            next_cause.debug = 1'b0;
            next_cause.wdt = 1'b0;
            next_cause.brownout = 1'b0;
            next_cause.pin = 1'b0;
        end
        if (debug_reset_req) begin
            next_cause.debug = 1'b1;
        end
        if (wdt_reset_pulse) begin
            next_cause.wdt = 1'b1;
        end
        if (bod_valid) begin
            next_cause.brownout = 1'b1;
        end
        if (pin_pending) begin
            next_cause.pin = 1'b1;
        end
        if (por_low) begin
            next_cause.power_on = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cause <= `CAUSE_RESET;
        end else begin
            cause <= next_cause;
        end
    end

    // ****************************************************************
    // Watchdog control register
    // ****************************************************************
    assign toe_write = wr_fire && sel_wdctrl && wr_bits[`BIT_TURNOFF];
    assign en_write_zero = wr_fire && sel_wdctrl && !wr_bits[`BIT_WD_ENABLE];

    always_comb begin
        next_wd_ctrl = wd_ctrl;
        if (wr_fire && sel_wdctrl) begin
            next_wd_ctrl.prescale = wr_bits[`PRESCALE_MSB:`PRESCALE_LSB];
            if (wr_bits[`BIT_WD_ENABLE]) begin
                next_wd_ctrl.enable = 1'b1;
            end else if (wd_ctrl.turnoff) begin
                next_wd_ctrl.enable = 1'b0;
            end
        end
        if (toe_write) begin
            next_wd_ctrl.turnoff = 1'b1;
        end else if (wd_ctrl.turnoff && toe_cnt == 3'(`TOE_HOLD_CYC - 1)) begin
            next_wd_ctrl.turnoff = 1'b0;
        end
    end

    // Register returns to defaults while the chip is held in reset
    always_ff @(posedge clk_sys) begin
        if (rst || chip_reset) begin
            wd_ctrl <= `WDCTRL_RESET;
            toe_cnt <= 3'h0;
        end else begin
            wd_ctrl <= next_wd_ctrl;
            toe_cnt <= toe_write ? 3'h0 :
                       wd_ctrl.turnoff ? toe_cnt + 3'h1 : 3'h0;
        end
    end

    // ****************************************************************
    // Watchdog timer
    // ****************************************************************
    // Oscillator modelled as a tick divided from the system clock
    assign osc_tick = (osc_div == 8'(OSC_DIV - 1));

    always_ff @(posedge clk_sys) begin
        if (rst || osc_tick) begin
            osc_div <= 8'h00;
        end else begin
            osc_div <= osc_div + 8'h01;
        end
    end

    assign wdt_limit = WDT_W'(WDT_BASE) << wd_ctrl.prescale;
    assign wdt_expire = wd_ctrl.enable && osc_tick &&
                        (wdt_cnt == wdt_limit - 1'b1);

    always_ff @(posedge clk_sys) begin
        if (rst || chip_reset || !wd_ctrl.enable) begin
            wdt_cnt <= '0;
        end else if (watchdog_restart || wdt_expire) begin
            wdt_cnt <= '0;
        end else if (osc_tick) begin
            wdt_cnt <= wdt_cnt + 1'b1;
        end
    end

    // A restart in the expiry cycle wins and no pulse is made
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wdt_reset_pulse <= 1'b0;
        end else begin
            wdt_reset_pulse <= wdt_expire && !watchdog_restart && !chip_reset;
        end
    end

    // ****************************************************************
    // Reference and level outputs
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bandgap_enable <= 1'b0;
            brownout_level_high <= 1'b0;
        end else begin
            bandgap_enable <= brownout_enable_setting ||
                              comparator_bandgap_select ||
                              converter_enable;
            brownout_level_high <= brownout_level_select;
        end
    end

endmodule
`default_nettype wire

// file: dv/reset_src_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module reset_src_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rst_pin_n,
    input wire logic por_low,
    input wire logic brownout_detector,
    input wire logic brownout_enable_setting,
    input wire logic brownout_level_select,
    input wire logic comparator_bandgap_select,
    input wire logic converter_enable,
    input wire logic chip_reset,
    input wire logic wdt_reset_pulse,
    input wire logic bandgap_enable,
    input wire logic brownout_level_high
);
    // ****************************************************************
    // Run length of enabled low supply, saturating to stay small
    // ****************************************************************
    logic [4:0] bod_run;
    always_ff @(posedge clk_sys) begin
        if (rst || !(brownout_detector && brownout_enable_setting)) begin
            bod_run <= 5'h00;
        end else if (bod_run != 5'h1F) begin
            bod_run <= bod_run + 5'h01;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    pulse_single_a: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
        else $error("watchdog pulse longer than one cycle");
    wdt_reset_a: assert property (wdt_reset_pulse |-> ##[1:2] chip_reset)
        else $error("watchdog timeout gave no chip reset");
    por_hold_a: assert property (por_low |=> chip_reset)
        else $error("low supply did not hold reset");
    pin_force_a: assert property (!rst_pin_n |-> chip_reset)
        else $error("reset pin low without chip reset");
    pin_stretch_a: assert property ($rose(rst_pin_n) && !por_low |-> chip_reset[*3])
        else $error("reset released before startup delay");
    bod_reset_a: assert property (bod_run >= 5'h17 |-> chip_reset)
        else $error("long brownout gave no reset");
    bandgap_or_a: assert property (1'b1 |=> bandgap_enable == $past(
        brownout_enable_setting | comparator_bandgap_select | converter_enable))
        else $error("bandgap enable wrong");
    level_copy_a: assert property (1'b1 |=>
        brownout_level_high == $past(brownout_level_select))
        else $error("brownout level wrong");
endmodule

bind reset_source_and_watchdog reset_src_asserts u_chk (.clk_sys, .rst,
    .rst_pin_n, .por_low, .brownout_detector, .brownout_enable_setting,
    .brownout_level_select, .comparator_bandgap_select, .converter_enable,
    .chip_reset, .wdt_reset_pulse, .bandgap_enable, .brownout_level_high);
`default_nettype wire

// file: dv/supply_model.sv
`timescale 1ns/1ps
`default_nettype none
module supply_model (
    input wire logic clk_sys,
    output logic por_low,
    output logic rst_pin_n,
    output logic brownout_detector
);
    // Supply starts low so the block sees a real power-on
    initial begin
        por_low = 1'b1;
        rst_pin_n = 1'b1;
        brownout_detector = 1'b0;
    end
    // Kind 0 supply low, 1 pin pulled low, 2 brownout dip
    task dip(input int kind, input int len);
        @(posedge clk_sys);
        if (kind == 0) por_low <= 1'b1;
        if (kind == 1) rst_pin_n <= 1'b0;
        if (kind == 2) brownout_detector <= 1'b1;
        repeat (len) @(posedge clk_sys);
        por_low <= 1'b0;
        rst_pin_n <= 1'b1;
        brownout_detector <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: dv/reset_source_and_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) check_val(33'(a), 33'(b))
module reset_source_and_watchdog_tb;
    import reset_pkg::*;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic rst_pin_n, por_low, brownout_detector, brownout_enable_setting;
    logic brownout_level_select, debug_reset_req, watchdog_restart;
    logic comparator_bandgap_select, converter_enable;
    logic chip_reset, wdt_reset_pulse, bandgap_enable, brownout_level_high;
    logic [32:0] exp_q[$];
    logic [2:0] presc;
    int err_count, total_checks, n;

    supply_model sm (.clk_sys, .por_low, .rst_pin_n, .brownout_detector);
    reset_source_and_watchdog #(.WDT_BASE(4), .START_BASE(2)) dut (
        .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rst_pin_n, .por_low, .brownout_detector,
        .brownout_enable_setting, .brownout_level_select, .debug_reset_req,
        .watchdog_restart, .comparator_bandgap_select, .converter_enable,
        .startup_delay_select(2'b00), .chip_reset, .wdt_reset_pulse,
        .bandgap_enable, .brownout_level_high);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task check_val(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Read results carry pslverr above the data word
    always @(posedge clk_sys) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            `CHK({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // ****************************************************************
    // Bus and wait helpers
    // ****************************************************************
    // Chain keeps psel up so a second write follows with no idle cycle
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             input logic chain);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            err_count++;
            end_of_test();
        end
        penable <= 1'b0;
        if (!chain) begin
            psel <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0, 1'b0);
    endtask
    task wait_run;
        n = 0;
        while (chip_reset !== 1'b0 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 3000) begin
            err_count++;
            end_of_test();
        end
    endtask

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {3'h4, 41'h0};
        {brownout_enable_setting, brownout_level_select} = 2'h0;
        {debug_reset_req, watchdog_restart} = 2'h0;
        {comparator_bandgap_select, converter_enable} = 2'h0;
        err_count = 0;
        total_checks = 0;
        void'($urandom(32'h841E3C9C));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        sm.dip(0, 2);
        wait_run();
        rd(8'h00, 33'h001);
        rd(8'h04, 33'h000);
        rd(8'h0C, 33'h100000000);
        sm.dip(1, 3);
        wait_run();
        rd(8'h00, 33'h003);
        apb(1'b1, 8'h00, 32'h1D, 1'b0);
        rd(8'h00, 33'h001);
        apb(1'b1, 8'h00, 32'h00, 1'b0);
        rd(8'h00, 33'h000);
        brownout_enable_setting <= 1'b1;
        sm.dip(2, 15);
        repeat (5) @(posedge clk_sys);
        rd(8'h00, 33'h000);
        sm.dip(2, 40);
        wait_run();
        rd(8'h00, 33'h004);
        debug_reset_req <= 1'b1;
        repeat (3) @(posedge clk_sys);
        debug_reset_req <= 1'b0;
        wait_run();
        rd(8'h00, 33'h014);
        sm.dip(0, 3);
        wait_run();
        rd(8'h00, 33'h001);
        for (int i = 0; i < 16; i++) begin
            {brownout_level_select, brownout_enable_setting,
             comparator_bandgap_select, converter_enable} <= 4'(i);
            repeat (2) @(posedge clk_sys);
            `CHK({brownout_level_high, bandgap_enable}, {i[3], |i[2:0]});
        end
        // Timeout is base shifted left by prescale, in ticks of ten clocks
        presc = 3'($urandom % 8);
        apb(1'b1, 8'h04, {27'h0, 2'b01, presc}, 1'b0);
        n = 0;
        while (wdt_reset_pulse !== 1'b1 && n < 6000) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(n >= (40 << presc) - 10 && n <= (40 << presc) + 20, 1);
        wait_run();
        rd(8'h00, 33'h009);
        rd(8'h04, 33'h000);
        apb(1'b1, 8'h04, 32'h08, 1'b0);
        repeat (6) begin
            // Restart well inside the shortest timeout of forty clocks
            repeat (20) @(posedge clk_sys);
            watchdog_restart <= 1'b1;
            @(posedge clk_sys);
            watchdog_restart <= 1'b0;
        end
        rd(8'h04, 33'h008);
        apb(1'b1, 8'h04, 32'h18, 1'b1);
        apb(1'b1, 8'h04, 32'h00, 1'b0);
        rd(8'h04, 33'h000);
        apb(1'b1, 8'h04, 32'h08, 1'b0);
        apb(1'b1, 8'h04, 32'h18, 1'b0);
        repeat (6) @(posedge clk_sys);
        apb(1'b1, 8'h04, 32'h00, 1'b0);
        rd(8'h04, 33'h008);
        end_of_test();
    end
endmodule
`default_nettype wire
